// ---- core/port6_pkg.sv ----
// package: register indices, reset values and field positions for port 6
package port6_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_OUTPUT_LATCH = 4'h0;
  localparam logic [3:0] ADDR_DIRECTION    = 4'h1;
  localparam logic [3:0] ADDR_PULLUP_EN    = 4'h2;
  localparam logic [3:0] ADDR_TIMER_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_STATUS       = 4'h4;
  // reset values
  localparam logic [7:0] RESET_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RESET_DIRECTION    = 8'h00;
  localparam logic [7:0] RESET_PULLUP_EN    = 8'h00;
  localparam logic       RESET_TIMER_OUT_A  = 1'b0;
  // field positions
  localparam int unsigned BIT_TIMER_OUT_A   = 0;
  localparam int unsigned PIN_TIMER_OUT_A   = 1;
  localparam int unsigned PIN_CLOCK_IN      = 0;
  localparam int unsigned PIN_CAPTURE_A     = 2;
  localparam int unsigned PIN_CAPTURE_B     = 3;
  localparam int unsigned BIT_STAT_STANDBY  = 0;
  localparam int unsigned BIT_STAT_HW_STBY  = 1;
  localparam logic [7:0]  READ_UNMAPPED     = 8'h00;
endpackage

// ---- core/port6_pin_cell.sv ----
// one port 6 pin: function select, pull-up gating and read-back select
`timescale 1ns/1ns
module port6_pin_cell (
  // configuration
  input  wire logic latchBit,
  input  wire logic dirBit,
  input  wire logic pullEnBit,
  input  wire logic altOutEn,
  input  wire logic altOutVal,
  input  wire logic forceOff,
  // pin
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe,
  output logic      pullOn,
  // read-back
  output logic      readBit
);
  always_comb begin
    if (altOutEn) begin
      pinOut = altOutVal;
      pinOe  = 1'b1;
    end else begin
      pinOut = latchBit;
      pinOe  = dirBit;
    end
  end

  // pull-up only with the direction bit clear and its enable set, never while held
  always_comb begin
    pullOn = pullEnBit & ~dirBit & ~forceOff;
  end

  always_comb begin
    readBit = dirBit ? latchBit : pinIn;
  end
endmodule

// ---- core/port6_pin_select_and_pullups.sv ----
// port 6 pin-function selection and per-pin programmable input pull-ups
//
// Contract
// - each port 6 pin has switchable pull-up
// - pull-up on only when enabled and direction bit clear
// - reset, hardware standby clear pull-up enables
// - pull-ups held off in reset, hardware standby
// - software standby keeps pull-up settings unchanged
// - pin 1 drives compare out A when enabled
// - read: latch if output, pin if input
// - pull-up enable register 8-bit, read/write, zero
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
module port6_pin_select_and_pullups
  import port6_pkg::*;
#(
  parameter int unsigned WIDTH = PORT_WIDTH
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // standby modes
  input  wire logic                  hwStandby,
  input  wire logic                  swStandby,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [7:0]            regRdata,
  // free-running timer
  input  wire logic                  timerCompareOutA,
  output logic                       timerCaptureInA,
  output logic                       timerCaptureInB,
  output logic                       timerExtClockIn,
  // key-sense
  output logic      [WIDTH-1:0]      keySenseInput,
  // pins
  input  wire logic [WIDTH-1:0]      pinIn,
  output logic      [WIDTH-1:0]      pinOut,
  output logic      [WIDTH-1:0]      pinOe,
  output logic      [WIDTH-1:0]      pullupOn
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (WIDTH != 8) begin : gWidthCheck
    $error("port width must be 8");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [WIDTH-1:0] outputLatch_q;
  logic [WIDTH-1:0] directionBits_q;
  logic [WIDTH-1:0] pullupEnableReg_q;
  logic             timerOutAEnable_q;
  logic             clearAll;
  logic             wrAllowed;
  logic [WIDTH-1:0] readBack;

  // hardware standby acts as a reset on every software-visible register
  assign clearAll  = ~rstn | hwStandby;
  // software standby freezes the core, so no write can land there
  assign wrAllowed = regWrite & ~swStandby;

  always_ff @(posedge clk) begin
    if (clearAll) begin
      pullupEnableReg_q <= RESET_PULLUP_EN;
    end else if (wrAllowed && regAddr == ADDR_PULLUP_EN) begin
      pullupEnableReg_q <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (clearAll) begin
      directionBits_q <= RESET_DIRECTION;
    end else if (wrAllowed && regAddr == ADDR_DIRECTION) begin
      directionBits_q <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (clearAll) begin
      outputLatch_q <= RESET_OUTPUT_LATCH;
    end else if (wrAllowed && regAddr == ADDR_OUTPUT_LATCH) begin
      outputLatch_q <= regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (clearAll) begin
      timerOutAEnable_q <= RESET_TIMER_OUT_A;
    end else if (wrAllowed && regAddr == ADDR_TIMER_CTRL) begin
      timerOutAEnable_q <= regWdata[BIT_TIMER_OUT_A];
    end
  end

  // ****************************************************************
  // per-pin cells
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : gPin
    port6_pin_cell uCell (
      .latchBit  (outputLatch_q[i]),
      .dirBit    (directionBits_q[i]),
      .pullEnBit (pullupEnableReg_q[i]),
      .altOutEn  ((i == PIN_TIMER_OUT_A) ? timerOutAEnable_q : 1'b0),
      .altOutVal (timerCompareOutA),
      .forceOff  (clearAll),
      .pinIn     (pinIn[i]),
      .pinOut    (pinOut[i]),
      .pinOe     (pinOe[i]),
      .pullOn    (pullupOn[i]),
      .readBit   (readBack[i])
    );
  end

  // ****************************************************************
  // peripheral inputs take the pin level in either direction
  // ****************************************************************
  assign timerCaptureInA = pinIn[PIN_CAPTURE_A];
  assign timerCaptureInB = pinIn[PIN_CAPTURE_B];
  assign timerExtClockIn = pinIn[PIN_CLOCK_IN];
  assign keySenseInput   = pinIn;

  // ****************************************************************
  // read data, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_OUTPUT_LATCH: regRdata <= readBack;
        ADDR_DIRECTION:    regRdata <= directionBits_q;
        ADDR_PULLUP_EN:    regRdata <= pullupEnableReg_q;
        ADDR_TIMER_CTRL:   regRdata <= {7'h00, timerOutAEnable_q};
        ADDR_STATUS: begin
          regRdata                   <= 8'h00;
          regRdata[BIT_STAT_STANDBY] <= swStandby;
          regRdata[BIT_STAT_HW_STBY] <= hwStandby;
        end
        default:           regRdata <= READ_UNMAPPED;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// ---- verification/port6_checker_assertions.sv ----
// checker for port 6 pin select and pull-ups
`timescale 1ns/1ns
module port6_checker (
  input wire logic       clk, rstn, hwStandby, swStandby, regWrite, regRead,
  input wire logic       timerCompareOutA, timerCaptureInA, timerCaptureInB,
  input wire logic       timerExtClockIn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata, regRdata, keySenseInput, pinIn,
  input wire logic [7:0] pinOut, pinOe, pullupOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wp;
  assign wp = regWrite && regAddr == 4'h2 && !swStandby && !hwStandby;
  // pin 1 is masked: its enable may come from the timer, not direction
  pull_gate_a: assert property (wp |=> (pullupOn & 8'hFD) ==
    ($past(regWdata) & ~pinOe & 8'hFD)) else $error("pull-up gate");
  hw_off_a: assert property (hwStandby |-> pullupOn == 8'h00)
    else $error("pull-up on in standby");
  hw_clear_a: assert property (hwStandby |=> pinOe == 8'h00 &&
    pullupOn == 8'h00) else $error("standby clear");
  sw_keep_a: assert property (swStandby && $past(swStandby) &&
    !hwStandby && !$past(hwStandby) |-> $stable(pullupOn) && $stable(pinOe))
    else $error("software standby change");
  out_a_sel_a: assert property (regWrite && regAddr == 4'h3 &&
    regWdata[0] && !swStandby && !hwStandby |=> pinOe[1] &&
    pinOut[1] == timerCompareOutA) else $error("compare out A");
  in_copy_a: assert property (keySenseInput == pinIn &&
    timerCaptureInA == pinIn[2] && timerCaptureInB == pinIn[3] &&
    timerExtClockIn == pinIn[0]) else $error("input copy");
  read_idle_a: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data idle");
  pull_read_a: assert property (wp ##1 regRead && regAddr == 4'h2 &&
    !hwStandby |=> regRdata == $past(regWdata, 2)) else $error("pull read");
  port_read_a: assert property (regRead && regAddr == 4'h0 &&
    !hwStandby |=> ((regRdata ^ $past(pinIn)) & ~$past(pinOe) & 8'hFD) ==
    8'h00) else $error("port read");
  cover property (swStandby && pullupOn != 8'h00);
  cover property (wp ##1 regRead);
  cover property (pinOe[1] && pinOut[1]);
endmodule
bind port6_pin_select_and_pullups port6_checker port6_checker_i (.*);

// ---- verification/pin_board_model.sv ----
// board model on the port 6 pins
`timescale 1ns/1ns
module pin_board_model (
  input  wire logic       clk,
  input  wire logic [7:0] pinOut, pinOe, pullupOn, extDrv, extVal,
  output logic      [7:0] pinIn
);
  logic [7:0] float_q = 8'h55;
  // undriven lines wander so a missing pull-up cannot hide behind 0 or 1
  always @(posedge clk) float_q <= ~float_q;
  assign pinIn = pinOe & pinOut |
    ~pinOe & (extDrv & extVal | ~extDrv & (pullupOn | float_q));
endmodule

// ---- verification/port6_pin_select_and_pullups_tb.sv ----
// self-checking bench for port 6 pin select and pull-ups
`timescale 1ns/1ns
module port6_pin_select_and_pullups_tb;
  import port6_pkg::*;
  logic clk = 0, rstn = 0, hwStandby = 0, swStandby = 0, regWrite = 0;
  logic regRead = 0, timerCompareOutA = 0, timerCaptureInA, timerCaptureInB;
  logic timerExtClockIn;
  logic [3:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata, keySenseInput, pinIn, pinOut, pinOe;
  logic [7:0] pullupOn, extDrv = 0, extVal = 0, lat, dir, pe, lvl;
  int failures = 0, n_checks = 0, seed = 32'hfc90, t;
  always #25 clk = ~clk;
  port6_pin_select_and_pullups port6_pin_select_and_pullups_i (.*);
  pin_board_model pin_board_model_i (.*);
  task automatic chk(string n, logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] exp_pull(logic [7:0] en, d);
    return en & ~d;
  endfunction
  // an undriven input pin reads its pull-up level
  function automatic logic [7:0] exp_level(logic [7:0] l, d, drv, v);
    return l & d | ~d & (drv & v | ~drv);
  endfunction
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    regWrite <= 1;
    regAddr <= a;
    regWdata <= d;
  endtask
  task automatic tick;
    @(posedge clk);
    regWrite <= 0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, string n);
    @(posedge clk);
    regWrite <= 0;
    regRead <= 1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 0;
    #1 chk(n, e, regRdata);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 chk("pull in reset", 8'h00, pullupOn);
    @(posedge clk) rstn <= 1;
    for (t = 1; t < 6; t++) rd(4'(t), 8'h00, "reset");
    $display("reset test done");
    for (t = 0; t < 24; t++) begin
      {lat, dir, pe, extVal} = $random(seed);
      if (t < 2) {dir, pe} = {{8{t[0]}}, 8'hFF};
      // inputs left undriven only where the pull-up will be on
      extDrv = ~dir & (~pe | 8'($random(seed)));
      wr(ADDR_OUTPUT_LATCH, lat);
      wr(ADDR_DIRECTION, dir);
      wr(ADDR_PULLUP_EN, pe);
      rd(ADDR_PULLUP_EN, pe, "pull reg");
      lvl = exp_level(lat, dir, extDrv, extVal);
      chk("pull", exp_pull(pe, dir), pullupOn);
      chk("key", lvl, keySenseInput);
      chk("timer in", {5'h00, lvl[3:2], lvl[0]}, {5'h00, timerCaptureInB,
        timerCaptureInA, timerExtClockIn});
      rd(ADDR_OUTPUT_LATCH, lvl, "port");
    end
    $display("random test done");
    wr(ADDR_TIMER_CTRL, 8'h01);
    wr(ADDR_DIRECTION, 8'h00);
    for (t = 0; t < 2; t++) begin
      timerCompareOutA <= t[0];
      tick;
      chk("out a", {6'h01, t[0]}, {6'h00, pinOe[1], pinOut[1]});
    end
    wr(ADDR_TIMER_CTRL, 8'h00);
    tick;
    chk("out a off", 8'h00, pinOe);
    $display("timer test done");
    wr(ADDR_PULLUP_EN, 8'h5A);
    tick;
    swStandby <= 1;
    wr(ADDR_PULLUP_EN, 8'hA5);
    wr(ADDR_DIRECTION, 8'hFF);
    tick;
    chk("sw pull", 8'h5A, pullupOn);
    rd(ADDR_STATUS, 8'h01, "status");
    swStandby <= 0;
    hwStandby <= 1;
    tick;
    chk("hw pull", 8'h00, pullupOn);
    hwStandby <= 0;
    rd(ADDR_PULLUP_EN, 8'h00, "hw clear");
    $display("standby test done");
    finish_test;
  end
  // a hang counts as a mismatch
  initial begin
    #100000;
    failures++;
    finish_test;
  end
endmodule
